// File: verilog/uart_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SERIAL_CONTROL_ADDR 8'h98
`define SERIAL_BUFFER_ADDR 8'h99
`define BAUD_RELOAD_ADDR 8'h9A
`define BAUD_CONTROL_ADDR 8'h9B
`define SERIAL_MODE_ADDR 8'h9C
`define IRQ_STATUS_ADDR 8'h9D
`define IRQ_MASK_ADDR 8'h9E
`define SC_SET_ADDR 8'hA0
`define SC_CLEAR_ADDR 8'hA1
`define SLAVE_ADDRESS_ADDR 8'hA9
`define SLAVE_MASK_ADDR 8'hB9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SC_MODE_HIGH 7
`define SC_MODE_LOW 6
`define SC_MULTIPROC 5
`define SC_RX_ENABLE 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_DONE 1
`define SC_RX_DONE 0
`define BC_RUN 4
`define BC_TX_SEL 3
`define BC_RX_SEL 2
`define BC_FAST 1
`define BC_M0_SRC 0
`define SM_DOUBLE_RATE 7
`define SM_ERR_ACCESS 6
`define SM_DOUBLER 0
`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_FE 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SERIAL_CONTROL_RESET 8'h00
`define BAUD_RELOAD_RESET 8'h00
`define SLAVE_ADDRESS_RESET 8'h00
`define SLAVE_MASK_RESET 8'h00

// ----------------------------------------
// Timing counts (clock cycles or ticks, value minus one except the mode 0 divisor)
// ----------------------------------------
`define BIT_LAST_TICK 4'hF
`define BIT_SAMPLE_TICK 4'h7
`define PRESC_FAST_X2 4'h0
`define PRESC_FAST 4'h1
`define PRESC_SLOW_X2 4'h5
`define PRESC_SLOW 4'hB
`define M2_TOP_BASE 2'h3
`define M2_TOP_HALF 2'h1
`define M2_TOP_QUARTER 2'h0
`define M0_FIXED_DIV 12

`endif

// File: verilog/uart_pkg.sv
// Types shared by the serial port and its rate generator
package uart_pkg;

   // ----------------------------------------
   // State machine encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_NINTH = 3'b011,
      TX_STOP = 3'b100,
      TX_SHIFT0 = 3'b101
   } tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP = 3'b100
   } rx_state_e;

   // ----------------------------------------
   // Module state records
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] pre;
      logic [7:0] cnt;
      logic half;
      logic tick;
   } rate_s;

   typedef struct packed {
      logic [7:0] sc;
      logic fe;
      logic [7:0] rx_buf;
      logic [7:0] reload;
      logic [7:0] slave_address;
      logic [7:0] slave_address_mask;
      logic [4:0] bc;
      logic [7:0] smode;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [7:0] rdata;
      tx_state_e tx_state;
      logic [3:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [7:0] tx_sh;
      logic txd;
      logic m0_rx;
      logic m0_phase;
      logic rxd_out;
      logic rxd_oe;
      logic [3:0] m0_div;
      logic [1:0] m2_div;
      rx_state_e rx_state;
      logic [3:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_ninth;
      logic rx_prev;
   } core_s;

endpackage

// File: verilog/rate_gen.sv
// Internal reload-based rate generator producing the 16x bit-rate tick
`timescale 1ns/100ps
`include "uart_cfg.svh"

module rate_gen (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [7:0] reload,
   input wire logic fast_rate_select,
   input wire logic clock_doubler,
   input wire logic double_rate_select,
   output logic tick
);

   uart_pkg::rate_s r_reg;
   uart_pkg::rate_s r_next;
   logic [3:0] presc_top;

   // ----------------------------------------
   // Prescaler and reload counter
   // ----------------------------------------
   // Prescale 2*6^(1-fast)/2^doubler, then count reload..255, then halve unless double rate
   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (fast_rate_select) begin
         presc_top = clock_doubler ? `PRESC_FAST_X2 : `PRESC_FAST;
      end else begin
         presc_top = clock_doubler ? `PRESC_SLOW_X2 : `PRESC_SLOW;
      end
      // A stopped generator sits on its reload so a restart counts a full period
      if (!run) begin
         r_next.pre = 4'h0;
         r_next.cnt = reload;
         r_next.half = 1'b0;
      end else if (r_reg.pre >= presc_top) begin
         r_next.pre = 4'h0;
         if (r_reg.cnt == 8'hFF) begin
            r_next.cnt = reload;
            if (double_rate_select) begin
               r_next.tick = 1'b1;
            end else begin
               r_next.half = ~r_reg.half;
               r_next.tick = r_reg.half;
            end
         end else begin
            r_next.cnt = r_reg.cnt + 8'h01;
         end
      end else begin
         r_next.pre = r_reg.pre + 4'h1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tick = r_reg.tick;

endmodule // rate_gen

// File: verilog/uart_core.sv
// Serial port with multiprocessor addressing, framing check and internal rate generator
// Function
// - The internal generator gives a bit rate of 2^double_rate*2^doubler*Fosc/(4*6^(1-fast)*16*(256-reload)).
// - Mode 0 may be clocked by the internal generator when mode0_clock_select is set.
// - In modes 2 and 3 the transmitter sends tx_ninth_bit as the ninth data bit.
// - A set tx_ninth_bit sends a 1 and a cleared one sends a 0 in the ninth position.
// - In modes 2 and 3 the receiver loads rx_ninth_bit with the received ninth bit.
// - In mode 1 with multiproc_enable clear the received stop bit goes to rx_ninth_bit.
// - In mode 0 rx_ninth_bit is never updated by the receiver.
// - tx_done_flag is set after the eighth bit in mode 0 and at the start of the stop bit otherwise.
// - In mode 0 rx_done_flag is set at the end of the eighth received bit.
// - The serial control register resets to zero and offers single-bit set and clear writes.
// - The serial buffer content is undefined after reset and must not be relied on.
// - Clearing generator_run halts the generator, setting it starts counting from the reload value.
// - In modes 1 and 3 the transmit and receive clocks pick timer 1 or the internal generator independently, 1 meaning internal.
// - The individual address is the slave address with bits of mask zero treated as don't-care.
// - The broadcast address is slave address OR mask, with zero bits of the result as don't-care.
`timescale 1ns/100ps
`include "uart_cfg.svh"

module uart_core #(
   parameter int M0_DIV = `M0_FIXED_DIV
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic timer1_tick,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd_out,
   output logic irq
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (M0_DIV < 4 || M0_DIV > 32 || (M0_DIV % 4) != 0) begin : bad_m0_div
      $error("M0_DIV must be a multiple of 4 between 4 and 32");
   end

   localparam logic [3:0] M0_TOP = 4'(M0_DIV / 2 - 1); // A bit is two ticks, so a tick is half the bit time
   localparam logic [3:0] M0_TOP_X2 = 4'(M0_DIV / 4 - 1);

   uart_pkg::core_s r_reg;
   uart_pkg::core_s r_next;
   logic gen_tick;
   logic [1:0] mode;
   logic [3:0] m0_top;
   logic [1:0] m2_top;
   logic m0_tick;
   logic m2_tick;
   logic tx_tick;
   logic rx_tick;
   logic [7:0] bcast;
   logic addressed;

   // ----------------------------------------
   // Rate generator
   // ----------------------------------------
   rate_gen rate_gen_inst (
      .clock(clock),
      .rst_n(rst_n),
      .run(r_reg.bc[`BC_RUN]),
      .reload(r_reg.reload),
      .fast_rate_select(r_reg.bc[`BC_FAST]),
      .clock_doubler(r_reg.smode[`SM_DOUBLER]),
      .double_rate_select(r_reg.smode[`SM_DOUBLE_RATE]),
      .tick(gen_tick)
   );

   // ----------------------------------------
   // Tick selection
   // ----------------------------------------
   // Mode from the two select bits; bit 7 holds the high select bit even while it reads as the error flag
   assign mode = {r_reg.sc[`SC_MODE_HIGH], r_reg.sc[`SC_MODE_LOW]};
   assign m0_top = r_reg.smode[`SM_DOUBLER] ? M0_TOP_X2 : M0_TOP;
   assign m0_tick = r_reg.bc[`BC_M0_SRC] ? gen_tick : (r_reg.m0_div == m0_top);
   assign m2_tick = (r_reg.m2_div == m2_top);
   // Mode 2 uses a fixed fraction of the clock, modes 1 and 3 the selected source
   assign tx_tick = (mode == 2'b10) ? m2_tick : (r_reg.bc[`BC_TX_SEL] ? gen_tick : timer1_tick);
   assign rx_tick = (mode == 2'b10) ? m2_tick : (r_reg.bc[`BC_RX_SEL] ? gen_tick : timer1_tick);

   // Mode 2 tick period: 4 cycles, halved by each of double rate and doubler
   always_comb begin
      case ({r_reg.smode[`SM_DOUBLE_RATE], r_reg.smode[`SM_DOUBLER]})
         2'b00: m2_top = `M2_TOP_BASE;
         2'b11: m2_top = `M2_TOP_QUARTER;
         default: m2_top = `M2_TOP_HALF;
      endcase
   end

   // ----------------------------------------
   // Address recognition
   // ----------------------------------------
   // Zero mask bits are don't-care for the given address, zero OR bits for broadcast
   assign bcast = r_reg.slave_address | r_reg.slave_address_mask;
   assign addressed = (((r_reg.rx_sh ^ r_reg.slave_address) & r_reg.slave_address_mask) == 8'h00)
      || (((r_reg.rx_sh ^ bcast) & bcast) == 8'h00);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic [7:0] view;
      logic stop_bit;
      logic accept;
      view = 8'h00;
      stop_bit = 1'b0;
      accept = 1'b0;
      r_next = r_reg;
      r_next.rdata = 8'h00;
      r_next.rx_prev = rxd_in;

      // Free-running fixed dividers for mode 0 and mode 2
      r_next.m0_div = (r_reg.m0_div >= m0_top) ? 4'h0 : r_reg.m0_div + 4'h1;
      r_next.m2_div = (r_reg.m2_div >= m2_top) ? 2'h0 : r_reg.m2_div + 2'h1;

      // Software view of the control register, bit 7 steered by the access select
      view = r_reg.sc;
      if (r_reg.smode[`SM_ERR_ACCESS]) begin
         view[7] = r_reg.fe;
      end
      if (wr && addr == `SERIAL_CONTROL_ADDR) begin
         view = wdata;
      end else if (wr && addr == `SC_SET_ADDR) begin
         view = view | wdata;
      end else if (wr && addr == `SC_CLEAR_ADDR) begin
         view = view & ~wdata;
      end
      r_next.sc[6:0] = view[6:0];
      // Software may only clear the error flag; a later valid frame leaves it alone
      if (r_reg.smode[`SM_ERR_ACCESS]) begin
         r_next.fe = r_reg.fe & view[7];
      end else begin
         r_next.sc[7] = view[7];
      end

      // Plain register writes, chained decode
      if (wr) begin
         if (addr == `BAUD_RELOAD_ADDR) begin
            r_next.reload = wdata;
         end else if (addr == `BAUD_CONTROL_ADDR) begin
            r_next.bc = wdata[4:0];
         end else if (addr == `SERIAL_MODE_ADDR) begin
            r_next.smode = wdata & 8'hC1;
         end else if (addr == `IRQ_STATUS_ADDR) begin
            r_next.ist = r_reg.ist & ~wdata[2:0];
         end else if (addr == `IRQ_MASK_ADDR) begin
            r_next.imask = wdata[2:0];
         end else if (addr == `SLAVE_ADDRESS_ADDR) begin
            r_next.slave_address = wdata;
         end else if (addr == `SLAVE_MASK_ADDR) begin
            r_next.slave_address_mask = wdata;
         end
      end

      // Register reads, answered in the next cycle; unmapped reads return zero
      if (rd) begin
         if (addr == `SERIAL_CONTROL_ADDR) begin
            r_next.rdata = r_reg.smode[`SM_ERR_ACCESS] ? {r_reg.fe, r_reg.sc[6:0]} : r_reg.sc;
         end else if (addr == `SERIAL_BUFFER_ADDR) begin
            r_next.rdata = r_reg.rx_buf;
         end else if (addr == `BAUD_RELOAD_ADDR) begin
            r_next.rdata = r_reg.reload;
         end else if (addr == `BAUD_CONTROL_ADDR) begin
            r_next.rdata = {3'b000, r_reg.bc};
         end else if (addr == `SERIAL_MODE_ADDR) begin
            r_next.rdata = r_reg.smode;
         end else if (addr == `IRQ_STATUS_ADDR) begin
            r_next.rdata = {5'b00000, r_reg.ist};
         end else if (addr == `IRQ_MASK_ADDR) begin
            r_next.rdata = {5'b00000, r_reg.imask};
         end else if (addr == `SLAVE_ADDRESS_ADDR) begin
            r_next.rdata = r_reg.slave_address;
         end else if (addr == `SLAVE_MASK_ADDR) begin
            r_next.rdata = r_reg.slave_address_mask;
         end
      end

      // Transmit engine; a buffer write while busy is dropped to keep the frame intact
      case (r_reg.tx_state)
         uart_pkg::TX_IDLE: begin
            if (wr && addr == `SERIAL_BUFFER_ADDR) begin
               r_next.tx_sh = wdata;
               r_next.tx_cnt = 4'h0;
               r_next.tx_bit = 4'h0;
               if (mode == 2'b00) begin
                  r_next.tx_state = uart_pkg::TX_SHIFT0;
                  r_next.m0_rx = 1'b0;
                  r_next.m0_phase = 1'b0;
                  r_next.rxd_oe = 1'b1;
                  r_next.rxd_out = wdata[0];
               end else begin
                  r_next.tx_state = uart_pkg::TX_START;
                  r_next.txd = 1'b0;
               end
            end else if (mode == 2'b00 && r_reg.sc[`SC_RX_ENABLE] && !r_reg.sc[`SC_RX_DONE]) begin
               // Mode 0 reception shares the shift clock, so it runs in this engine
               r_next.tx_state = uart_pkg::TX_SHIFT0;
               r_next.tx_bit = 4'h0;
               r_next.m0_rx = 1'b1;
               r_next.m0_phase = 1'b0;
               r_next.rxd_oe = 1'b0;
            end
         end
         uart_pkg::TX_SHIFT0: begin
            if (m0_tick) begin
               r_next.m0_phase = ~r_reg.m0_phase;
               if (!r_reg.m0_phase) begin
                  r_next.txd = 1'b0;
               end else begin
                  r_next.txd = 1'b1;
                  r_next.tx_bit = r_reg.tx_bit + 4'h1;
                  if (r_reg.m0_rx) begin
                     r_next.rx_sh = {rxd_in, r_reg.rx_sh[7:1]};
                  end else begin
                     r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
                     r_next.rxd_out = r_reg.tx_sh[1];
                  end
                  if (r_reg.tx_bit == 4'h7) begin
                     r_next.tx_state = uart_pkg::TX_IDLE;
                     r_next.rxd_oe = 1'b0;
                     r_next.rxd_out = 1'b0;
                     if (r_reg.m0_rx) begin
                        r_next.rx_buf = {rxd_in, r_reg.rx_sh[7:1]};
                        r_next.sc[`SC_RX_DONE] = 1'b1;
                        r_next.ist[`IRQ_RX] = 1'b1;
                     end else begin
                        r_next.sc[`SC_TX_DONE] = 1'b1;
                        r_next.ist[`IRQ_TX] = 1'b1;
                     end
                  end
               end
            end
         end
         default: begin
            if (tx_tick) begin
               r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
               if (r_reg.tx_cnt == `BIT_LAST_TICK) begin
                  case (r_reg.tx_state)
                     uart_pkg::TX_START: begin
                        r_next.tx_state = uart_pkg::TX_DATA;
                        r_next.txd = r_reg.tx_sh[0];
                     end
                     uart_pkg::TX_DATA: begin
                        r_next.tx_bit = r_reg.tx_bit + 4'h1;
                        r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
                        r_next.txd = r_reg.tx_sh[1];
                        if (r_reg.tx_bit == 4'h7) begin
                           if (mode[1]) begin
                              r_next.tx_state = uart_pkg::TX_NINTH;
                              r_next.txd = r_reg.sc[`SC_TX_NINTH];
                           end else begin
                              r_next.tx_state = uart_pkg::TX_STOP;
                              r_next.txd = 1'b1;
                              r_next.sc[`SC_TX_DONE] = 1'b1;
                              r_next.ist[`IRQ_TX] = 1'b1;
                           end
                        end
                     end
                     uart_pkg::TX_NINTH: begin
                        r_next.tx_state = uart_pkg::TX_STOP;
                        r_next.txd = 1'b1;
                        r_next.sc[`SC_TX_DONE] = 1'b1;
                        r_next.ist[`IRQ_TX] = 1'b1;
                     end
                     default: begin
                        r_next.tx_state = uart_pkg::TX_IDLE;
                     end
                  endcase
               end
            end
         end
      endcase

      // Receive engine for modes 1 to 3; single sample at the middle of each bit
      case (r_reg.rx_state)
         uart_pkg::RX_IDLE: begin
            if (mode != 2'b00 && r_reg.sc[`SC_RX_ENABLE] && r_reg.rx_prev && !rxd_in) begin
               r_next.rx_state = uart_pkg::RX_START;
               r_next.rx_cnt = 4'h0;
               r_next.rx_bit = 4'h0;
            end
         end
         default: begin
            if (rx_tick) begin
               r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
               if (r_reg.rx_cnt == `BIT_SAMPLE_TICK) begin
                  case (r_reg.rx_state)
                     uart_pkg::RX_START: begin
                        // A start bit gone high by mid-bit was a glitch
                        if (rxd_in) begin
                           r_next.rx_state = uart_pkg::RX_IDLE;
                        end
                     end
                     uart_pkg::RX_DATA: begin
                        r_next.rx_sh = {rxd_in, r_reg.rx_sh[7:1]};
                     end
                     uart_pkg::RX_NINTH: begin
                        r_next.rx_ninth = rxd_in;
                     end
                     default: begin
                        // Stop bit: finish at mid-bit so the next start edge is not missed
                        stop_bit = rxd_in;
                        r_next.rx_state = uart_pkg::RX_IDLE;
                        if (!stop_bit) begin
                           r_next.fe = 1'b1;
                           r_next.ist[`IRQ_FE] = 1'b1;
                        end
                        accept = !r_reg.sc[`SC_RX_DONE] && (!r_reg.sc[`SC_MULTIPROC] ||
                           ((mode[1] ? r_reg.rx_ninth : stop_bit) && addressed));
                        if (accept) begin
                           r_next.rx_buf = r_reg.rx_sh;
                           r_next.sc[`SC_RX_DONE] = 1'b1;
                           r_next.ist[`IRQ_RX] = 1'b1;
                           if (mode[1]) begin
                              r_next.sc[`SC_RX_NINTH] = r_reg.rx_ninth;
                           end else if (!r_reg.sc[`SC_MULTIPROC]) begin
                              r_next.sc[`SC_RX_NINTH] = stop_bit;
                           end
                        end
                     end
                  endcase
               end else if (r_reg.rx_cnt == `BIT_LAST_TICK) begin
                  case (r_reg.rx_state)
                     uart_pkg::RX_START: begin
                        r_next.rx_state = uart_pkg::RX_DATA;
                     end
                     uart_pkg::RX_DATA: begin
                        r_next.rx_bit = r_reg.rx_bit + 4'h1;
                        if (r_reg.rx_bit == 4'h7) begin
                           r_next.rx_state = mode[1] ? uart_pkg::RX_NINTH : uart_pkg::RX_STOP;
                        end
                     end
                     uart_pkg::RX_NINTH: begin
                        r_next.rx_state = uart_pkg::RX_STOP;
                     end
                     default: begin
                        r_next.rx_state = r_reg.rx_state;
                     end
                  endcase
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Buffer content is cleared only for simulation hygiene; software must not rely on it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.sc <= `SERIAL_CONTROL_RESET;
         r_reg.reload <= `BAUD_RELOAD_RESET;
         r_reg.slave_address <= `SLAVE_ADDRESS_RESET;
         r_reg.slave_address_mask <= `SLAVE_MASK_RESET;
         r_reg.txd <= 1'b1;
         r_reg.rx_prev <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata = r_reg.rdata;
   assign txd_out = r_reg.txd;
   assign rxd_out = r_reg.rxd_out;
   assign rxd_oe = r_reg.rxd_oe;
   assign irq = |(r_reg.ist & r_reg.imask);

endmodule // uart_core

// File: dv/uart_core_checker.sv
// Register bus and interrupt checks of the serial port
`timescale 1ns/100ps
module uart_core_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Read data stand one cycle; unmapped and reserved places read zero
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
   unmapped_read_a: assert property (rd && !(addr inside {8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E,
      8'hA0, 8'hA1, 8'hA9, 8'hB9}) |=> rdata == 8'h00) else $error("unmapped read");
   rate_rsvd_a: assert property (rd && addr == 8'h9B |=> rdata[7:5] == 3'h0) else $error("rate bits");
   mode_rsvd_a: assert property (rd && addr == 8'h9C |=> rdata[5:1] == 5'h00) else $error("mode bits");
   status_rsvd_a: assert property (rd && addr == 8'h9D |=> rdata[7:3] == 5'h00) else $error("status bits");
   // A cleared mask silences the interrupt at once
   mask_quiet_a: assert property (wr && addr == 8'h9E && wdata == 8'h00 |=> !irq) else $error("irq");
   // Written values come back on the next read
   addr_back_a: assert property (wr && addr == 8'hA9 ##2 rd && addr == 8'hA9 |=> rdata == $past(wdata, 3))
      else $error("address readback");
   reload_back_a: assert property (wr && addr == 8'h9A ##2 rd && addr == 8'h9A |=> rdata == $past(wdata, 3))
      else $error("reload readback");
endmodule // uart_core_checker
bind uart_core uart_core_checker uart_core_checker_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// File: dv/serial_station.sv
// Remote serial station that sends one frame on the receive line
`timescale 1ns/100ps
module serial_station #(
   parameter int BIT_CYCLES = 32
) (
   input wire logic clock,
   input wire logic go,
   input wire logic [10:0] frame,
   input wire logic [3:0] nbits,
   output logic line,
   output logic busy
);
   // Line rests high between frames, as a pulled-up idle line does
   initial line = 1'b1;
   initial busy = 1'b0;
   // Bits leave LSB first, each held one full bit period
   always begin
      do @(posedge clock); while (!go);
      busy <= 1'b1;
      for (int i = 0; i < nbits; i++) begin
         line <= frame[i];
         repeat (BIT_CYCLES) @(posedge clock);
      end
      line <= 1'b1;
      busy <= 1'b0;
   end
endmodule // serial_station

// File: dv/uart_core_test.sv
// Self-checking bench of the serial port
`timescale 1ns/100ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h", $time, g); end end
module uart_core_test;
   logic clock, rst_n, wr, rd, timer1_tick, go, probe, rd_q, busy, rxd_in, txd_out, irq, rxd_out, rxd_oe;
   logic [7:0] addr, wdata, rdata, seed, e;
   logic [10:0] frame;
   logic [3:0] nbits;
   logic [7:0] expq[$];
   logic [7:0] raddr[9] = '{8'h98, 8'h9A, 8'hA9, 8'hB9, 8'hC0, 8'h9B, 8'h9C, 8'h9D, 8'h9E};
   int errors, tests_run, cycles;
   uart_core uart_core_inst (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .timer1_tick(timer1_tick), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
      .txd_out(txd_out), .irq(irq));
   serial_station serial_station_inst (.clock(clock), .go(go), .frame(frame), .nbits(nbits), .line(rxd_in),
      .busy(busy));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // One bus cycle; a read notes the value it should return
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= v;
      if (!w) expq.push_back(v);
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Station sends a frame; the timeout guards the wait
   task automatic send(input logic [3:0] n);
      nbits = n;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      while (busy) @(posedge clock);
   endtask
   // Probe the line at mid-bit for each of the 11 frame bits, gap cycles apart
   task automatic watch(input int gap);
      while (txd_out) @(posedge clock);
      repeat (gap / 2) @(posedge clock);
      for (int i = 0; i < 11; i++) begin
         expq.push_back({7'h00, frame[i]});
         probe <= 1'b1;
         @(posedge clock);
         probe <= 1'b0;
         repeat (gap - 1) @(posedge clock);
      end
   endtask
   task automatic summarize();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Timer 1 ticks every other cycle, so one bit lasts 32 cycles
   always @(posedge clock) timer1_tick <= ~timer1_tick;
   // Oldest note is compared when a read answer or line probe appears
   always @(posedge clock) begin
      rd_q <= rd;
      cycles++;
      if (rd_q || probe) begin
         e = expq.pop_front();
         `CHECK(rd_q ? rdata : {7'h00, txd_out}, e)
      end
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {wr, rd, go, probe, rd_q, timer1_tick, rst_n} = 7'h00;
      addr = 8'h00;
      wdata = 8'h00;
      seed = 8'h20;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      foreach (raddr[i]) op(1'b0, raddr[i], 8'h00);
      for (int i = 1; i < 4; i++) begin
         seed = lfsr(seed);
         op(1'b1, raddr[i], seed);
         op(1'b0, raddr[i], seed);
      end
      op(1'b1, 8'h9E, 8'h01);
      op(1'b1, 8'h98, 8'hC8);
      seed = lfsr(seed);
      frame = {2'b11, seed, 1'b0};
      op(1'b1, 8'h99, seed);
      watch(32);
      `CHECK(irq, 1'b1)
      op(1'b0, 8'h9D, 8'h01);
      op(1'b0, 8'h98, 8'hCA);
      op(1'b1, 8'h9D, 8'h01);
      op(1'b1, 8'h9E, 8'h00);
      op(1'b1, 8'h98, 8'hD0);
      for (int n = 0; n < 2; n++) begin
         seed = lfsr(seed);
         frame = {1'b1, n[0], seed, 1'b0};
         send(4'hB);
         op(1'b0, 8'h99, seed);
         op(1'b0, 8'h98, 8'hD1 | {5'h00, n[0], 2'h0});
         op(1'b1, 8'hA1, 8'h01);
      end
      op(1'b1, 8'h98, 8'h50);
      send(4'hA);
      op(1'b0, 8'h98, 8'h55);
      op(1'b1, 8'h98, 8'h50);
      frame = {2'b10, seed, 1'b0};
      send(4'hA);
      op(1'b1, 8'h9C, 8'h40);
      op(1'b0, 8'h98, 8'hD1);
      op(1'b1, 8'h98, 8'h50);
      op(1'b0, 8'h98, 8'h50);
      // Internal generator, fast, reload FF: one tick per 4 cycles, 64 cycles a bit
      op(1'b1, 8'h9C, 8'h00);
      op(1'b1, 8'h9A, 8'hFF);
      op(1'b1, 8'h9B, 8'h1A);
      op(1'b1, 8'h98, 8'h40);
      frame = {2'b11, seed, 1'b0};
      op(1'b1, 8'h99, seed);
      watch(64);
      // Mode 0 transmit on the fixed divider: 8 bits of 6-cycle halves end well within 110 cycles
      op(1'b1, 8'h98, 8'h00);
      op(1'b1, 8'h99, seed);
      @(posedge clock);
      `CHECK({rxd_oe, rxd_out}, {1'b1, seed[0]})
      repeat (110) @(posedge clock);
      `CHECK(rxd_oe, 1'b0)
      op(1'b0, 8'h98, 8'h02);
      summarize();
   end
endmodule // uart_core_test
